//--- shared/sipo_regs.svh
// constants and functional notes for the serial-in parallel-out driver register
//==============================================================
// Functional notes
// - 8-bit shift register feeds storage register
// - shift_clock rise shifts in serial_in
// - latch_clock rise copies shift into storage
// - storage reaches outputs only while clear_n high
// - clear_n low clears every register
// - controller clears device at initialization
// - output_enable_n high forces all outputs off
// - output_enable_n low: outputs follow storage
// - high bit turns its drain switch on
// - controller may PWM output_enable_n for dimming
// - serial_out presents data leaving shift register
// - chain serial_out to next serial_in
// - controller presents one bit per shift_clock
// - two devices: sixteen shifts, then latch
// - stored one turns load on, zero off
`ifndef SIPO_REGS_SVH
`define SIPO_REGS_SVH
`define SIPO_WIDTH 8
`define SIPO_RESET_VAL 8'h00
`define SIPO_LINK_PERIOD_NS 125
`define SIPO_CLK_PERIOD_NS 8
// half period of the generated link clock, rounded down, at least one
`define SIPO_HALF_CYC ((`SIPO_LINK_PERIOD_NS / `SIPO_CLK_PERIOD_NS) / 2)
`endif

//--- shared/sipo_pkg.sv
// types shared by both ends of the driver register link
`default_nettype none
package sipo_pkg;
  typedef enum logic [1:0]
  {
    SIPO_IDLE = 2'b00,
    SIPO_SHIFT = 2'b01,
    SIPO_LATCH = 2'b11,
    SIPO_DONE = 2'b10
  } sipo_state_e;
endpackage : sipo_pkg
`default_nettype wire

//--- shared/sipo_if.sv
// pin-level link between controller and driver register
`timescale 1ns/1ps
`default_nettype none
interface sipo_if;
  logic shift_clock;
  logic latch_clock;
  logic serial_in;
  logic serial_out;
  logic clear_n;
  logic output_enable_n;
  modport ctrl
  (
    output shift_clock,
    output latch_clock,
    output serial_in,
    output clear_n,
    output output_enable_n,
    input serial_out
  );
  modport dev
  (
    input shift_clock,
    input latch_clock,
    input serial_in,
    input clear_n,
    input output_enable_n,
    output serial_out
  );
endinterface : sipo_if
`default_nettype wire

//--- hdl/sipo_dev.sv
// device end: shift register, storage register, output gating
`timescale 1ns/1ps
`default_nettype none
`include "sipo_regs.svh"
module sipo_dev
  import sipo_pkg::*;
#(
  parameter int WIDTH = `SIPO_WIDTH
)
(
  input wire logic clk,
  input wire logic rst_b,
  sipo_if.dev link,
  output logic [WIDTH-1:0] drain_on,
  output logic [WIDTH-1:0] drain_oe_b
);
  if (WIDTH < 2)
  begin : g_bad_width
    $error("WIDTH must be at least 2");
  end
  //==============================================================
  // helpers
  // edge seen between the second and third flop of a synchroniser
  function automatic logic rose_at(input logic [2:0] s);
    return s[1] && !s[2];
  endfunction : rose_at
  //==============================================================
  // state
  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] lck_s;
    logic [1:0] sin_s;
    logic [1:0] clr_s;
    logic [1:0] oe_s;
    logic [WIDTH-1:0] shift;
    logic [WIDTH-1:0] store;
    logic [WIDTH-1:0] drv;
    logic sout;
  } sipo_dev_s;
  sipo_dev_s st_q, st_d;
  //==============================================================
  // next state; pins pass two flops, edges found on the third
  always_comb
  begin
    st_d = st_q;
    st_d.sck_s = {st_q.sck_s[1:0], link.shift_clock};
    st_d.lck_s = {st_q.lck_s[1:0], link.latch_clock};
    st_d.sin_s = {st_q.sin_s[0], link.serial_in};
    st_d.clr_s = {st_q.clr_s[0], link.clear_n};
    st_d.oe_s = {st_q.oe_s[0], link.output_enable_n};
    if (!st_q.clr_s[1])
    begin
      st_d.shift = WIDTH'(`SIPO_RESET_VAL);
      st_d.store = WIDTH'(`SIPO_RESET_VAL);
    end
    else
    begin
      if (rose_at(st_q.sck_s))
        st_d.shift = {st_q.shift[WIDTH-2:0], st_q.sin_s[1]};
      if (rose_at(st_q.lck_s))
        st_d.store = st_q.shift;
    end
    // output buffer: gated by clear and enable, transparent otherwise
    if (st_q.oe_s[1] || !st_q.clr_s[1])
      st_d.drv = '0;
    else
      st_d.drv = st_d.store;
    st_d.sout = st_d.shift[WIDTH-1];
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign link.serial_out = st_q.sout;
  assign drain_on = st_q.drv;
  // open drain: enable low sinks current
  assign drain_oe_b = ~st_q.drv;
endmodule : sipo_dev
`default_nettype wire

//--- hdl/sipo_ctrl.sv
// controller end: sends a frame of bits then pulses the latch clock
`timescale 1ns/1ps
`default_nettype none
`include "sipo_regs.svh"
module sipo_ctrl
  import sipo_pkg::*;
#(
  parameter int NBITS = 2 * `SIPO_WIDTH,
  parameter int HALF = `SIPO_HALF_CYC
)
(
  input wire logic clk,
  input wire logic rst_b,
  sipo_if.ctrl link,
  input wire logic [NBITS-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic clear_req,
  input wire logic dim_n,
  output logic busy
);
  //==============================================================
  // elaboration checks; the counters are eight bits wide and the
  // shifter needs at least two bits
  if (NBITS < 2 || NBITS > 255)
  begin : g_bad_nbits
    $error("NBITS must be 2..255");
  end
  if (HALF < 1 || HALF > 255)
  begin : g_bad_half
    $error("HALF must be 1..255");
  end
  //==============================================================
  // state: two-entry buffer plus serialiser
  typedef struct packed {
    // frame buffer
    logic [1:0][NBITS-1:0] buf_w;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    // serialiser
    sipo_state_e fsm;
    logic [NBITS-1:0] sh;
    logic [7:0] bits;
    logic [7:0] tmr;
    logic phase;
    // link pins, straight from flops so the far end sees no glitch
    logic sck;
    logic lck;
    logic sin;
    logic clr_n;
    logic oe_n;
  } sipo_ctrl_s;
  sipo_ctrl_s st_q, st_d;
  logic push;
  logic pop;
  logic tick;
  logic last_bit;
  logic [NBITS-1:0] head;
  //==============================================================
  // helpers
  // eight-bit step shared by the half-period timer and the bit count
  function automatic logic [7:0] step8(input logic [7:0] v);
    return v + 8'h01;
  endfunction : step8
  //==============================================================
  // buffer handshake
  // in_ready is combinational so a sender can push back to back
  assign in_ready = (st_q.cnt != 2'h2);
  assign push = in_valid && in_ready;
  // no frame starts while the far end is held in clear
  assign pop = (st_q.fsm == SIPO_IDLE) && (st_q.cnt != 2'h0) && st_q.clr_n;
  assign head = st_q.buf_w[st_q.rp];
  //==============================================================
  // half-period timing
  assign tick = (st_q.tmr == 8'(HALF - 1));
  assign last_bit = (st_q.bits == 8'(NBITS - 1));
  //==============================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    // enable and clear are registered so the pins change on a clock
    st_d.oe_n = dim_n;
    st_d.clr_n = !clear_req;
    if (tick)
    begin
      st_d.tmr = 8'h00;
    end
    else
    begin
      st_d.tmr = step8(st_q.tmr);
    end
    // two-entry buffer: a stalled serialiser loses no frame
    if (push)
    begin
      st_d.buf_w[st_q.wp] = in_data;
      st_d.wp = !st_q.wp;
    end
    if (pop)
    begin
      st_d.rp = !st_q.rp;
    end
    st_d.cnt = st_q.cnt + 2'(push) - 2'(pop);
    case (st_q.fsm)
      SIPO_IDLE:
      begin
        st_d.sck = 1'b0;
        st_d.lck = 1'b0;
        // load the head frame; the timer restarts so that the first
        // half period is a full one
        if (pop)
        begin
          st_d.sh = head;
          st_d.bits = 8'h00;
          st_d.phase = 1'b0;
          st_d.tmr = 8'h00;
          st_d.fsm = SIPO_SHIFT;
        end
      end
      SIPO_SHIFT:
      begin
        if (tick)
        begin
          if (!st_q.phase)
          begin
            // first half: the next bit goes out while the clock is low
            st_d.sin = st_q.sh[NBITS-1];
            st_d.sck = 1'b0;
            st_d.phase = 1'b1;
          end
          else
          begin
            // second half: the bit has stood a full half period
            st_d.sck = 1'b1;
            st_d.sh = {st_q.sh[NBITS-2:0], 1'b0};
            st_d.bits = step8(st_q.bits);
            st_d.phase = 1'b0;
            if (last_bit)
            begin
              st_d.fsm = SIPO_LATCH;
            end
          end
        end
      end
      SIPO_LATCH:
      begin
        // the last shift pulse keeps its full width, then one latch
        // pulse a half period wide
        if (tick)
        begin
          st_d.sck = 1'b0;
          if (!st_q.phase)
          begin
            st_d.lck = 1'b1;
            st_d.phase = 1'b1;
          end
          else
          begin
            st_d.lck = 1'b0;
            st_d.phase = 1'b0;
            st_d.fsm = SIPO_DONE;
          end
        end
      end
      SIPO_DONE:
      begin
        // a quiet half period before the next frame may start
        st_d.sck = 1'b0;
        st_d.lck = 1'b0;
        if (tick)
        begin
          st_d.fsm = SIPO_IDLE;
        end
      end
      default:
      begin
        // a code outside the four states: back to idle with the clocks low
        st_d.sck = 1'b0;
        st_d.lck = 1'b0;
        st_d.fsm = SIPO_IDLE;
      end
    endcase
  end
  //==============================================================
  // registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // outputs start off and clear_n starts low: the far end stays
      // cleared until the first clock after reset
      st_q <= '0;
      st_q.oe_n <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end
  //==============================================================
  // link pins
  assign link.shift_clock = st_q.sck;
  assign link.latch_clock = st_q.lck;
  assign link.serial_in = st_q.sin;
  assign link.clear_n = st_q.clr_n;
  assign link.output_enable_n = st_q.oe_n;
  //==============================================================
  // status
  // busy covers buffered frames too, so a caller can wait for the
  // link to drain before touching clear_req or dim_n
  assign busy = (st_q.fsm != SIPO_IDLE) || (st_q.cnt != 2'h0);
endmodule : sipo_ctrl
`default_nettype wire

//--- bench/sipo_link_monitor.sv
// link pin checker
`timescale 1ns/1ps
`default_nettype none
module sipo_link_monitor #(parameter int NBITS = 16)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic shift_clock,
  input wire logic latch_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic clear_n
);
  logic [7:0] sh_q;
  logic [5:0] n_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  //==========================================
  // shadow stages; clears early, harmless since no shift runs during clear
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      sh_q <= 8'h00;
      n_q <= 6'h00;
    end
    else
    begin
      if (!clear_n)
        sh_q <= 8'h00;
      else if ($rose(shift_clock))
        sh_q <= {sh_q[6:0], serial_in};
      n_q <= $rose(latch_clock) ? 6'h00 : n_q + 6'($rose(shift_clock));
    end
  //==========================================
  // properties
  property p_pair; $rose(shift_clock) |-> ##5 serial_out == $past(sh_q[7], 4); endproperty
  a_pair: assert property (p_pair) else $error("bad serial_out");
  property p_clr; !clear_n [*5] |-> !serial_out; endproperty
  a_clr: assert property (p_clr) else $error("not cleared");
  property p_sw; $rose(shift_clock) |-> shift_clock [*7] ##1 !shift_clock; endproperty
  a_sw: assert property (p_sw) else $error("shift width");
  property p_lw; $rose(latch_clock) |-> latch_clock [*7] ##1 !latch_clock; endproperty
  a_lw: assert property (p_lw) else $error("latch width");
  property p_ex; latch_clock |-> !shift_clock; endproperty
  a_ex: assert property (p_ex) else $error("overlap");
  property p_sin; shift_clock |-> $stable(serial_in); endproperty
  a_sin: assert property (p_sin) else $error("data moved");
  property p_cnt; $rose(latch_clock) |-> n_q == NBITS; endproperty
  a_cnt: assert property (p_cnt) else $error("shift count");
  property p_gap; $fell(latch_clock) |-> !shift_clock [*7]; endproperty
  a_gap: assert property (p_gap) else $error("no idle");
  cover property ($rose(latch_clock));
  cover property ($fell(clear_n));
  cover property ($rose(serial_out));
endmodule : sipo_link_monitor
`default_nettype wire

//--- bench/testbench.sv
// bench: controller and driver register joined by the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b, in_valid, in_ready, clear_req, dim_n, busy, blk;
  logic [15:0] in_data;
  logic [7:0] drain_on;
  logic [7:0] drain_oe_b;
  int num_errors = 0;
  int compares = 0;
  sipo_if lk();
  // second device on the chain: shares clocks, clear and enable
  sipo_if lk_next();
  logic [7:0] drain_hi;
  logic [7:0] drain_hi_oe_b;
  assign lk_next.shift_clock = lk.shift_clock;
  assign lk_next.latch_clock = lk.latch_clock;
  assign lk_next.serial_in = lk.serial_out;
  assign lk_next.clear_n = lk.clear_n;
  assign lk_next.output_enable_n = lk.output_enable_n;
  always #4 clk = ~clk;
  sipo_ctrl u_sipo_ctrl (.clk(clk), .rst_b(rst_b), .link(lk), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .clear_req(clear_req), .dim_n(dim_n), .busy(busy));
  sipo_dev u_sipo_dev (.clk(clk), .rst_b(rst_b), .link(lk), .drain_on(drain_on),
    .drain_oe_b(drain_oe_b));
  sipo_dev u_sipo_dev_next (.clk(clk), .rst_b(rst_b), .link(lk_next), .drain_on(drain_hi),
    .drain_oe_b(drain_hi_oe_b));
  sipo_link_monitor #(.NBITS(16)) u_sipo_link_monitor (.clk(clk), .rst_b(rst_b),
    .shift_clock(lk.shift_clock), .latch_clock(lk.latch_clock), .serial_in(lk.serial_in),
    .serial_out(lk.serial_out), .clear_n(lk.clear_n));
  //==========================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // holds valid up between pushes so back-to-back frames never drop it
  task automatic push(input logic [15:0] d);
    logic ok;
    in_data <= d;
    in_valid <= 1'b1;
    do
    begin
      @(negedge clk);
      ok = in_ready;
      blk |= !ok;
      @(posedge clk);
    end
    while (!ok);
  endtask : push
  task automatic settle();
    int n;
    n = 0;
    while (n < 20)
    begin
      @(negedge clk);
      n = busy ? 0 : n + 1;
    end
    @(posedge clk);
  endtask : settle
  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  //==========================================
  // tests
  initial
  begin
    rst_b = 1'b0;
    in_valid = 1'b0;
    in_data = 16'h0000;
    clear_req = 1'b0;
    dim_n = 1'b0;
    blk = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("drain_on", 8'h00, drain_on);
    $display("end reset");
    push(16'hA5C3);
    in_valid <= 1'b0;
    settle();
    chk("drain_on", 8'hC3, drain_on);
    chk("drain_oe_b", 8'h3C, drain_oe_b);
    chk("serial_out", 8'h01, 8'(lk.serial_out));
    chk("drain_hi", 8'hA5, drain_hi);
    chk("drain_hi_oe_b", 8'h5A, drain_hi_oe_b);
    chk("serial_out_hi", 8'h01, 8'(lk_next.serial_out));
    $display("end frame");
    push(16'h1234);
    push(16'h0081);
    push(16'hFF7E);
    push(16'h00E7);
    in_valid <= 1'b0;
    settle();
    chk("refused", 8'h01, 8'(blk));
    chk("drain_on", 8'hE7, drain_on);
    chk("drain_hi", 8'h00, drain_hi);
    $display("end burst");
    dim_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("drain_on", 8'h00, drain_on);
    dim_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk("drain_on", 8'hE7, drain_on);
    $display("end enable");
    clear_req <= 1'b1;
    repeat (8) @(posedge clk);
    chk("drain_on", 8'h00, drain_on);
    clear_req <= 1'b0;
    repeat (8) @(posedge clk);
    chk("serial_out", 8'h00, 8'(lk.serial_out));
    chk("drain_on", 8'h00, drain_on);
    chk("drain_hi", 8'h00, drain_hi);
    $display("end clear");
    complete_run();
  end
  initial
  begin
    #100000;
    num_errors++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
